/* File: logic/ivg_top.sv */
// ofb initialization vector generator with call lock and key store
`timescale 1ns/100ps
`include "ivg_defines.svh"
// Function
// - 64-stage lfsr, taps 0,15,27,38,46,62,64
// - seed loaded into lfsr at transmission start
// - loaded seed is sent to receiver
// - 64 shifts give first 64-bit vector
// - receiver loads received seed, same shifting
// - new session sends state, shifts 64 again
// - output bits, msb first, feed input block
// - 128-bit mode captures outputs in buffer
// - 128-bit vector is lfsr then buffer
// - 2-bit cipher type selects three algorithms
// - 6-bit key alias, 64 shared by all types
// - 64-bit vector field seeds the lfsr
// - keys of 15, 56 and 256 bits
// - stored key is tied to its alias
// - voice scope 49 or 72 bits per frame
// - data scope octets 2-21, 2-15, 2-9
// - seed travels in iv or header message
// - field octet 1 holds bits 63 to 56
// - algorithm fixed for whole call
// - key fixed for whole call
// - first cipher pass not xored with data
// - scramble uses 15-stage pn, nonzero preset
module ivg_top
    import ivg_pkg::*;
#(
    parameter int KEY_SLOTS = `IVG_KEY_SLOTS,
    parameter int KEY_W = `IVG_KEY_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // call control
    input wire logic call_start,
    input wire logic call_end,
    input wire ivg_call_cfg_s call_cfg,
    input wire logic [63:0] seed_in,
    input wire logic next_session,
    // key loading
    input wire logic key_wr,
    input wire logic [`IVG_KEY_ALIAS_FIELD_W-1:0] key_wr_alias,
    input wire logic [KEY_W-1:0] key_wr_data,
    // cipher core feedback and pn advance
    input wire logic cipher_pass_done,
    input wire logic pn_advance,
    // seed hand-off toward the far end
    output logic seed_valid,
    output logic [63:0] seed_out,
    output ivg_msg_e seed_msg,
    // vector output
    output logic iv_valid,
    output logic [127:0] iv_out,
    output logic ofb_xor_en,
    // call state
    output logic call_active,
    output ivg_cipher_e active_cipher,
    output logic [KEY_W-1:0] active_key,
    output logic cfg_change_refused,
    output logic key_error,
    output logic busy,
    output ivg_scope_s scope,
    output logic pn_bit
);
    ivg_state_e state_q, state_d;
    logic [6:0] cnt_q;
    logic [63:0] lfsr_q, lfsr_nxt, buf_q, buf_nxt, seed_out_q;
    logic [KEY_W-1:0] key_mem_q [KEY_SLOTS];
    logic [KEY_W-1:0] key_sel, key_mask, key_q;
    ivg_call_cfg_s cfg_q;
    logic call_q, seed_valid_q, iv_valid_q, xor_en_q, refused_q, key_err_q, busy_q;
    ivg_msg_e seed_msg_q;
    logic [127:0] iv_q;
    logic [1:0] pass_q;
    ivg_scope_s scope_q;
    logic lfsr_out, blk_call, start_ok, session_go, last_shift, scr_preset, scr_zero, is_blk;

    // step logic for the vector register
    ivg_lfsr_step #(
        .W(64)
    ) u_step (
        .cur(lfsr_q),
        .nxt(lfsr_nxt),
        .out_bit(lfsr_out)
    );

    // scramble pn source, preset from the selected key
    ivg_scrambler #(
        .W(`IVG_SCR_W)
    ) u_scr (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .preset(scr_preset),
        .preset_val(key_sel[`IVG_SCR_W-1:0]),
        .advance(pn_advance & call_q & (cfg_q.cipher == IVG_CIPHER_SCRAMBLE)),
        .pn_bit(pn_bit)
    );

    // a new call is only taken while no call is active
    assign start_ok = call_start & ~call_q;
    assign is_blk = (call_cfg.cipher == IVG_CIPHER_BLK64)
                  | (call_cfg.cipher == IVG_CIPHER_BLK128);
    assign blk_call = (cfg_q.cipher == IVG_CIPHER_BLK64)
                    | (cfg_q.cipher == IVG_CIPHER_BLK128);
    // next session only between shifts; a request during shifting is dropped
    assign session_go = next_session & call_q & blk_call & (state_q == IVG_ST_IDLE);
    assign last_shift = (state_q == IVG_ST_SHIFT) & (cnt_q == `IVG_SHIFTS - 7'd1);
    assign key_sel = key_mem_q[call_cfg.key_alias_field];
    assign scr_zero = (key_sel[`IVG_SCR_W-1:0] == `IVG_RST_SCR);
    assign scr_preset = start_ok & (call_cfg.cipher == IVG_CIPHER_SCRAMBLE) & ~scr_zero;
    // buffer takes each output bit; first bit out ends at the top
    assign buf_nxt = {buf_q[62:0], lfsr_out};

    // effective key length per cipher type
    always_comb begin
        key_mask = '0;
        case (call_cfg.cipher)
            IVG_CIPHER_SCRAMBLE: key_mask[`IVG_KEY_SCR_LEN-1:0] = '1;
            IVG_CIPHER_BLK64: key_mask[`IVG_KEY_DES_LEN-1:0] = '1;
            IVG_CIPHER_BLK128: key_mask[`IVG_KEY_AES_LEN-1:0] = '1;
            default: key_mask = '0;
        endcase
    end

    // key store indexed by alias, written only outside calls
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < KEY_SLOTS; i++) begin
                key_mem_q[i] <= '0;
            end
        end else if (key_wr & ~call_q) begin
            key_mem_q[key_wr_alias] <= key_wr_data;
        end
    end

    // call lock: cipher type and key captured once per call
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            call_q <= 1'b0;
            cfg_q <= '0;
            key_q <= '0;
        end else if (start_ok) begin
            call_q <= 1'b1;
            cfg_q <= call_cfg;
            key_q <= key_sel & key_mask;
        end else if (call_end) begin
            call_q <= 1'b0;
        end
    end

    // a change attempt during a call is refused and flagged until the call ends, or until the next call start when made in the ending cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            refused_q <= 1'b0;
        end else if (start_ok) begin
            refused_q <= 1'b0;
        end else if (call_q & call_start) begin
            refused_q <= 1'b1;
        end else if (call_end) begin
            refused_q <= 1'b0;
        end
    end

    // all-zero scramble preset would lock the pn source at zero
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            key_err_q <= 1'b0;
        end else if (start_ok) begin
            key_err_q <= (call_cfg.cipher == IVG_CIPHER_SCRAMBLE) & scr_zero;
        end
    end

    // shift sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            IVG_ST_IDLE: begin
                if ((start_ok & is_blk) | session_go) begin
                    state_d = IVG_ST_SHIFT;
                end
            end
            IVG_ST_SHIFT: begin
                if (last_shift) begin
                    state_d = IVG_ST_IDLE;
                end
            end
            default: state_d = IVG_ST_IDLE;
        endcase
    end

    // state flop; busy mirrors the next state so the output comes from a flop
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= IVG_ST_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= (state_d == IVG_ST_SHIFT);
        end
    end

    // shift counter, one count per clock while shifting
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_q <= 7'd0;
        end else if (state_q == IVG_ST_SHIFT) begin
            cnt_q <= last_shift ? 7'd0 : cnt_q + 7'd1;
        end else begin
            cnt_q <= 7'd0;
        end
    end

    // lfsr: seed load at a block-cipher call start, one step per clock while shifting
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lfsr_q <= `IVG_RST_LFSR;
        end else if (start_ok & is_blk) begin
            lfsr_q <= seed_in;
        end else if (state_q == IVG_ST_SHIFT) begin
            lfsr_q <= lfsr_nxt;
        end
    end

    // output buffer collects the 64 bits shifted out
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            buf_q <= '0;
        end else if (state_q == IVG_ST_SHIFT) begin
            buf_q <= buf_nxt;
        end
    end

    // seed hand-off: loaded seed at start, present state at a new session
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seed_valid_q <= 1'b0;
            seed_out_q <= '0;
        end else if (start_ok & is_blk) begin
            seed_valid_q <= 1'b1;
            seed_out_q <= seed_in;
        end else if (session_go) begin
            seed_valid_q <= 1'b1;
            seed_out_q <= lfsr_q;
        end else begin
            seed_valid_q <= 1'b0;
        end
    end

    // carrier message for the seed follows the call kind
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            seed_msg_q <= IVG_MSG_NONE;
        end else if (start_ok) begin
            if (!is_blk) begin
                seed_msg_q <= IVG_MSG_NONE;
            end else if (call_cfg.kind == IVG_KIND_VOICE) begin
                seed_msg_q <= IVG_MSG_VOICE_IV;
            end else if (call_cfg.kind == IVG_KIND_DATA) begin
                seed_msg_q <= IVG_MSG_DATA_HEADER;
            end else begin
                seed_msg_q <= IVG_MSG_SHORT_DATA_IV;
            end
        end
    end

    // completed vector after the 64th shift; 128-bit is state then buffer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            iv_valid_q <= 1'b0;
            iv_q <= '0;
        end else if (last_shift) begin
            iv_valid_q <= 1'b1;
            if (cfg_q.cipher == IVG_CIPHER_BLK128) begin
                iv_q <= {lfsr_nxt, buf_nxt};
            end else begin
                iv_q <= {64'h0, buf_nxt};
            end
        end else begin
            iv_valid_q <= 1'b0;
        end
    end

    // ofb gate: the first cipher pass only reloads the input block
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pass_q <= 2'd0;
            xor_en_q <= 1'b0;
        end else if (iv_valid_q | ~call_q) begin
            pass_q <= 2'd0;
            xor_en_q <= 1'b0;
        end else if (cipher_pass_done & ~xor_en_q) begin
            pass_q <= pass_q + 2'd1;
            xor_en_q <= (pass_q + 2'd1 == `IVG_PASS_FIRST_XOR);
        end
    end

    // encryption scope per frame rate or message kind
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            scope_q <= '0;
        end else begin
            scope_q.voice_bits <= cfg_q.full_rate ? `IVG_FULL_RATE_BITS
                                                  : `IVG_HALF_RATE_BITS;
            scope_q.first_octet <= `IVG_OCT_FIRST;
            case (cfg_q.kind)
                IVG_KIND_DATA: scope_q.last_octet <= `IVG_OCT_LAST_DATA;
                IVG_KIND_SHORT_USER_PACKET_CHANNEL: begin
                    scope_q.last_octet <= `IVG_OCT_LAST_SHORT_PKT;
                end
                IVG_KIND_SHORT_FAST_ASSOC_CONTROL_CHANNEL: begin
                    scope_q.last_octet <= `IVG_OCT_LAST_SHORT_CTL;
                end
                default: scope_q.last_octet <= 5'd0;
            endcase
        end
    end

    // outputs straight from flops
    assign seed_valid = seed_valid_q;
    assign seed_out = seed_out_q;
    assign seed_msg = seed_msg_q;
    assign iv_valid = iv_valid_q;
    assign iv_out = iv_q;
    assign ofb_xor_en = xor_en_q;
    assign call_active = call_q;
    assign active_cipher = cfg_q.cipher;
    assign active_key = key_q;
    assign cfg_change_refused = refused_q;
    assign key_error = key_err_q;
    assign busy = busy_q;
    assign scope = scope_q;
endmodule

/* File: logic/ivg_defines.svh */
// constants for the ofb initialization vector generator
`ifndef IVG_DEFINES_SVH
`define IVG_DEFINES_SVH
`define IVG_LFSR_W 64
`define IVG_SHIFTS 7'd64
`define IVG_TAP_A 62
`define IVG_TAP_B 46
`define IVG_TAP_C 38
`define IVG_TAP_D 27
`define IVG_TAP_E 15
`define IVG_SCR_W 15
`define IVG_KEY_W 256
`define IVG_KEY_SCR_LEN 15
`define IVG_KEY_DES_LEN 56
`define IVG_KEY_AES_LEN 256
`define IVG_KEY_ALIAS_FIELD_W 6
`define IVG_KEY_SLOTS 64
`define IVG_HALF_RATE_BITS 7'd49
`define IVG_FULL_RATE_BITS 7'd72
`define IVG_OCT_FIRST 5'd2
`define IVG_OCT_LAST_DATA 5'd21
`define IVG_OCT_LAST_SHORT_PKT 5'd15
`define IVG_OCT_LAST_SHORT_CTL 5'd9
`define IVG_RST_LFSR 64'h0
`define IVG_RST_SCR 15'h0
`define IVG_PASS_FIRST_XOR 2'd2
`endif

/* File: logic/ivg_pkg.sv */
// types shared by the iv generator files
package ivg_pkg;
    typedef enum logic [1:0] {
        IVG_CIPHER_NONE = 2'b00,
        IVG_CIPHER_SCRAMBLE = 2'b01,
        IVG_CIPHER_BLK64 = 2'b10,
        IVG_CIPHER_BLK128 = 2'b11
    } ivg_cipher_e;
    typedef enum logic [1:0] {
        IVG_KIND_VOICE = 2'b00,
        IVG_KIND_DATA = 2'b01,
        IVG_KIND_SHORT_USER_PACKET_CHANNEL = 2'b10,
        IVG_KIND_SHORT_FAST_ASSOC_CONTROL_CHANNEL = 2'b11
    } ivg_kind_e;
    typedef enum logic [1:0] {
        IVG_MSG_NONE = 2'b00,
        IVG_MSG_VOICE_IV = 2'b01,
        IVG_MSG_DATA_HEADER = 2'b10,
        IVG_MSG_SHORT_DATA_IV = 2'b11
    } ivg_msg_e;
    typedef enum logic [1:0] {
        IVG_ST_IDLE = 2'b00,
        IVG_ST_SHIFT = 2'b01
    } ivg_state_e;
    typedef struct packed {
        ivg_cipher_e cipher;
        logic [5:0] key_alias_field;
        ivg_kind_e kind;
        logic full_rate;
    } ivg_call_cfg_s;
    typedef struct packed {
        logic [6:0] voice_bits;
        logic [4:0] first_octet;
        logic [4:0] last_octet;
    } ivg_scope_s;
endpackage

/* File: logic/ivg_lfsr_step.sv */
// one step of the 64-stage iv lfsr: next state and output bit
`timescale 1ns/100ps
`include "ivg_defines.svh"
module ivg_lfsr_step #(
    parameter int W = `IVG_LFSR_W
) (
    // present state
    input wire logic [W-1:0] cur,
    // next state and the bit shifted out
    output logic [W-1:0] nxt,
    output logic out_bit
);
    logic fb;
    // taps at powers 64,62,46,38,27,15; power k sits in bit k-1
    assign fb = cur[W-1] ^ cur[`IVG_TAP_A-1] ^ cur[`IVG_TAP_B-1]
              ^ cur[`IVG_TAP_C-1] ^ cur[`IVG_TAP_D-1] ^ cur[`IVG_TAP_E-1];
    assign out_bit = cur[W-1];
    assign nxt = {cur[W-2:0], fb};
endmodule

/* File: logic/ivg_scrambler.sv */
// 15-stage pn generator x^15+x+1 for scramble mode
`timescale 1ns/100ps
`include "ivg_defines.svh"
module ivg_scrambler #(
    parameter int W = `IVG_SCR_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // preset and advance
    input wire logic preset,
    input wire logic [W-1:0] preset_val,
    input wire logic advance,
    // pn output
    output logic pn_bit
);
    logic [W-1:0] state_q;
    logic [W-1:0] state_d;
    // period 32767 as long as the preset is not all zeros
    always_comb begin
        state_d = state_q;
        if (preset) begin
            state_d = preset_val;
        end else if (advance) begin
            state_d = {state_q[W-2:0], state_q[W-1] ^ state_q[0]};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= `IVG_RST_SCR;
        end else begin
            state_q <= state_d;
        end
    end
    assign pn_bit = state_q[W-1];
endmodule

/* File: testbench/ivg_top_sva.sv */
// port assertions for the iv generator
`timescale 1ns/100ps
module ivg_top_sva
    import ivg_pkg::*;
#(
    parameter int KEY_W = 256
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // requests
    input wire logic call_start,
    input wire logic call_end,
    input wire ivg_call_cfg_s call_cfg,
    input wire logic [63:0] seed_in,
    input wire logic next_session,
    input wire logic cipher_pass_done,
    // answers
    input wire logic seed_valid,
    input wire logic [63:0] seed_out,
    input wire ivg_msg_e seed_msg,
    input wire logic iv_valid,
    input wire logic [127:0] iv_out,
    input wire logic ofb_xor_en,
    input wire logic call_active,
    input wire ivg_cipher_e active_cipher,
    input wire logic [KEY_W-1:0] active_key,
    input wire logic cfg_change_refused,
    input wire logic busy
);
    logic [7:0] run_q;
    logic take_blk;
    logic [63:0] lfsr_half;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // length of one shifting run, cleared whenever idle
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !busy)
            run_q <= 8'h0;
        else
            run_q <= run_q + 8'h1;
    end
    // a call start with either block cipher
    assign take_blk = call_start && !call_active && call_cfg.cipher[1];
    assign lfsr_half = iv_out[127:64];
    property p_seed_sent;
        take_blk |=> seed_valid && seed_out == $past(seed_in);
    endproperty
    a_seed_sent: assert property (p_seed_sent) else $error("seed not handed on");
    property p_iv_time;
        seed_valid |-> ##64 iv_valid;
    endproperty
    a_iv_time: assert property (p_iv_time) else $error("vector not 64 shifts after seed");
    property p_run_len;
        iv_valid |-> run_q == 8'd64 && !busy;
    endproperty
    a_run_len: assert property (p_run_len) else $error("shift run not 64 cycles");
    property p_locked;
        call_active && $past(call_active) |-> $stable(active_cipher) && $stable(active_key);
    endproperty
    a_locked: assert property (p_locked) else $error("cipher or key moved in call");
    property p_refused;
        call_start && call_active && !call_end |=> cfg_change_refused;
    endproperty
    a_refused: assert property (p_refused) else $error("restart in call not refused");
    property p_msg;
        take_blk |=> seed_msg == ($past(call_cfg.kind) == IVG_KIND_VOICE ? IVG_MSG_VOICE_IV :
            $past(call_cfg.kind) == IVG_KIND_DATA ? IVG_MSG_DATA_HEADER : IVG_MSG_SHORT_DATA_IV);
    endproperty
    a_msg: assert property (p_msg) else $error("wrong seed carrier message");
    property p_next;
        next_session && call_active && !busy && active_cipher == IVG_CIPHER_BLK128
            |=> seed_valid && seed_out == $past(lfsr_half) && busy;
    endproperty
    a_next: assert property (p_next) else $error("new session seed not lfsr state");
    property p_xor_clear;
        iv_valid |=> !ofb_xor_en;
    endproperty
    a_xor_clear: assert property (p_xor_clear) else $error("xor enabled at fresh vector");
    property p_xor_cause;
        $rose(ofb_xor_en) |-> $past(cipher_pass_done);
    endproperty
    a_xor_cause: assert property (p_xor_cause) else $error("xor enabled without a pass");
    property p_upper_zero;
        iv_valid && active_cipher == IVG_CIPHER_BLK64 |-> lfsr_half == 64'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("64-bit vector upper half set");
endmodule

bind ivg_top ivg_top_sva #(.KEY_W(KEY_W)) sva_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .call_start(call_start), .call_end(call_end), .call_cfg(call_cfg), .seed_in(seed_in),
    .next_session(next_session), .cipher_pass_done(cipher_pass_done),
    .seed_valid(seed_valid), .seed_out(seed_out), .seed_msg(seed_msg), .iv_valid(iv_valid),
    .iv_out(iv_out), .ofb_xor_en(ofb_xor_en), .call_active(call_active),
    .active_cipher(active_cipher), .active_key(active_key),
    .cfg_change_refused(cfg_change_refused), .busy(busy));

/* File: testbench/ivg_rx_model.sv */
// far-end receiver: rebuilds the vector from the seed it was handed
`timescale 1ns/100ps
module ivg_rx_model (
    // clock
    input wire logic ref_clk,
    // seed from the sender
    input wire logic seed_valid,
    input wire logic [63:0] seed_out,
    input wire logic wide,
    // rebuilt vector
    output logic [127:0] rx_iv
);
    logic [63:0] st;
    logic [63:0] obuf;
    // sampled on the falling edge so the registered strobe has settled
    always @(negedge ref_clk) begin
        if (seed_valid === 1'b1) begin
            st = seed_out;
            for (int i = 0; i < 64; i++) begin
                obuf = {obuf[62:0], st[63]};
                st = {st[62:0], st[63] ^ st[61] ^ st[45] ^ st[37] ^ st[26] ^ st[14]};
            end
            rx_iv = wide ? {st, obuf} : {64'h0, obuf};
        end
    end
endmodule

/* File: testbench/ivg_top_bench.sv */
// self-checking bench for the iv generator
`timescale 1ns/100ps
module ivg_top_bench;
    import ivg_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic call_start = 1'b0;
    logic call_end = 1'b0;
    ivg_call_cfg_s call_cfg = '0;
    logic [63:0] seed_in = 64'h0;
    logic next_session = 1'b0;
    logic key_wr = 1'b0;
    logic [5:0] key_wr_alias = 6'h0;
    logic [255:0] key_wr_data = '0;
    logic cipher_pass_done = 1'b0;
    logic pn_advance = 1'b0;
    logic seed_valid, iv_valid, ofb_xor_en, call_active, cfg_change_refused, key_error, busy;
    logic pn_bit;
    logic [63:0] seed_out;
    ivg_msg_e seed_msg;
    logic [127:0] iv_out, rx_iv, prev_iv;
    ivg_cipher_e active_cipher;
    logic [255:0] active_key;
    ivg_scope_s scope;
    logic [14:0] pn_st;
    int num_errors = 0;
    int samples_checked = 0;
    ivg_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .call_start(call_start),
        .call_end(call_end), .call_cfg(call_cfg), .seed_in(seed_in), .next_session(next_session),
        .key_wr(key_wr), .key_wr_alias(key_wr_alias), .key_wr_data(key_wr_data),
        .cipher_pass_done(cipher_pass_done), .pn_advance(pn_advance), .seed_valid(seed_valid),
        .seed_out(seed_out), .seed_msg(seed_msg), .iv_valid(iv_valid), .iv_out(iv_out),
        .ofb_xor_en(ofb_xor_en), .call_active(call_active), .active_cipher(active_cipher),
        .active_key(active_key), .cfg_change_refused(cfg_change_refused), .key_error(key_error),
        .busy(busy), .scope(scope), .pn_bit(pn_bit));
    ivg_rx_model rx_u (.ref_clk(ref_clk), .seed_valid(seed_valid), .seed_out(seed_out),
        .wide(active_cipher == IVG_CIPHER_BLK128), .rx_iv(rx_iv));
    // free-running clock
    always #5 ref_clk = ~ref_clk;
    task automatic check(input logic [255:0] seen, input logic [255:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // each strobe task but start idles one cycle after, so no strobe is set twice in one step
    task automatic wkey(input logic [5:0] a, input logic [255:0] d);
        key_wr = 1'b1;
        key_wr_alias = a;
        key_wr_data = d;
        tick(1);
        key_wr = 1'b0;
        tick(1);
    endtask
    task automatic start(input ivg_cipher_e c, input logic [5:0] a, input ivg_kind_e k,
        input logic fr, input logic [63:0] s);
        call_cfg = '{c, a, k, fr};
        seed_in = s;
        call_start = 1'b1;
        tick(1);
        call_start = 1'b0;
    endtask
    task automatic end_call();
        call_end = 1'b1;
        tick(1);
        call_end = 1'b0;
        check({call_active, cfg_change_refused}, 2'b00);
        tick(1);
    endtask
    task automatic pass_done();
        cipher_pass_done = 1'b1;
        tick(1);
        cipher_pass_done = 1'b0;
        tick(1);
    endtask
    // bounded wait for the vector, then compare with the receiver's rebuild
    task automatic wait_iv();
        int n = 0;
        while (iv_valid !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check(n, 64);
        check(iv_out, rx_iv);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: the whole run needs well under ten microseconds
    initial begin
        #50us;
        num_errors++;
        print_verdict();
    end
    initial begin
        tick(4);
        sys_rst = 1'b0;
        check({call_active, seed_valid, iv_valid, busy}, 4'h0);
        wkey(6'h01, 256'h5a5a);
        wkey(6'h02, {256{1'b1}});
        wkey(6'h3f, {8{32'hc3a5_0f1e}});
        wkey(6'h04, 256'h8000);
        start(IVG_CIPHER_BLK64, 6'h02, IVG_KIND_VOICE, 1'b0, 64'h0123_4567_89ab_cdef);
        check(seed_valid, 1'b1);
        check(seed_out, 64'h0123_4567_89ab_cdef);
        check(seed_out[63:56], 8'h01);
        check(active_key, {200'h0, {56{1'b1}}});
        wait_iv();
        check(scope.voice_bits, 7'd49);
        start(IVG_CIPHER_BLK128, 6'h3f, IVG_KIND_DATA, 1'b1, 64'h1);
        check(cfg_change_refused, 1'b1);
        check(active_cipher, IVG_CIPHER_BLK64);
        wkey(6'h02, 256'h0);
        check(active_key, {200'h0, {56{1'b1}}});
        pass_done();
        check(ofb_xor_en, 1'b0);
        pass_done();
        check(ofb_xor_en, 1'b1);
        end_call();
        $display("test block64 done");
        for (int k = 0; k < 4; k++) begin
            start(IVG_CIPHER_BLK128, 6'h3f, ivg_kind_e'(k), 1'b1, 64'hfedc_ba98_7654_3210 + 64'(k));
            check(seed_msg, k == 0 ? IVG_MSG_VOICE_IV : k == 1 ? IVG_MSG_DATA_HEADER :
                IVG_MSG_SHORT_DATA_IV);
            check(active_key, {8{32'hc3a5_0f1e}});
            wait_iv();
            if (k == 0)
                check(scope.voice_bits, 7'd72);
            else
                check({scope.first_octet, scope.last_octet},
                    {5'd2, k == 1 ? 5'd21 : k == 2 ? 5'd15 : 5'd9});
            prev_iv = iv_out;
            next_session = 1'b1;
            tick(1);
            next_session = 1'b0;
            check({seed_valid, seed_out}, {1'b1, prev_iv[127:64]});
            wait_iv();
            end_call();
        end
        $display("test block128 done");
        start(IVG_CIPHER_SCRAMBLE, 6'h01, IVG_KIND_VOICE, 1'b0, 64'h0);
        check({key_error, active_cipher}, {1'b0, IVG_CIPHER_SCRAMBLE});
        check(active_key, 256'h5a5a);
        pn_advance = 1'b1;
        tick(10);
        pn_advance = 1'b0;
        pn_st = 15'h5a5a;
        repeat (10) pn_st = {pn_st[13:0], pn_st[14] ^ pn_st[0]};
        check(pn_bit, pn_st[14]);
        end_call();
        // the in-call write to alias 2 earlier must not have landed
        start(IVG_CIPHER_SCRAMBLE, 6'h02, IVG_KIND_VOICE, 1'b0, 64'h0);
        check(active_key, 256'h7fff);
        next_session = 1'b1;
        tick(1);
        next_session = 1'b0;
        check({seed_valid, busy}, 2'b00);
        end_call();
        start(IVG_CIPHER_SCRAMBLE, 6'h04, IVG_KIND_VOICE, 1'b0, 64'h0);
        check(key_error, 1'b1);
        end_call();
        start(IVG_CIPHER_NONE, 6'h00, IVG_KIND_DATA, 1'b0, 64'h0);
        check({call_active, seed_valid, active_cipher, seed_msg},
            {1'b1, 1'b0, IVG_CIPHER_NONE, IVG_MSG_NONE});
        end_call();
        $display("test scramble done");
        print_verdict();
    end
endmodule
